// ==== logic/pppc_blanking.sv ====
// Qualifies a fault level: fires once it has held for a given cycle count.
// Assumes the level is synchronous to mclk.
`timescale 1ns/100ps
`default_nettype none
module pppc_blanking #(
    parameter int CYCLES = pppc_pkg::BLANK_CYCLES
) (
    input  wire logic  mclk,     // Clock
    input  wire logic  rst_n,    // Sync reset
    input  wire logic  level,    // Raw fault level
    output logic       fired     // Held long enough
);
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic        next_fired;

    always_comb begin
        next_cnt   = cnt;
        next_fired = 1'b0;
        if (!level) begin
            next_cnt = '0;
        end else if (cnt >= 16'(CYCLES - 1)) begin
            next_fired = 1'b1;
        end else begin
            next_cnt = cnt + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt   <= '0;
            fired <= 1'b0;
        end else begin
            cnt   <= next_cnt;
            fired <= next_fired;
        end
    end
endmodule
`default_nettype wire

// ==== logic/pppc_ms_timer.sv ====
// Millisecond-scaled down counter; start loads a count, done pulses at zero.
// Assumes one synchronous clock.
`timescale 1ns/100ps
`default_nettype none
module pppc_ms_timer #(
    parameter int MS_CYCLES = pppc_pkg::MS_CYCLES
) (
    input  wire logic        mclk,     // Clock
    input  wire logic        rst_n,    // Sync reset
    input  wire logic        start,    // Load pulse
    input  wire logic        stop,     // Abandon count
    input  wire logic [5:0]  ms,       // Length in ms
    output logic             done      // Expiry pulse
);
    logic [pppc_pkg::CNT_W-1:0] cnt;
    logic [pppc_pkg::CNT_W-1:0] next_cnt;
    logic                       run;
    logic                       next_run;
    logic                       next_done;

    always_comb begin
        next_cnt  = cnt;
        next_run  = run;
        next_done = 1'b0;
        if (start) begin
            next_cnt = pppc_pkg::CNT_W'(ms * MS_CYCLES - 1);
            next_run = 1'b1;
        end else if (stop) begin
            next_run = 1'b0;
        end else if (run) begin
            if (cnt == '0) begin
                next_run  = 1'b0;
                next_done = 1'b1;
            end else begin
                next_cnt = cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt  <= '0;
            run  <= 1'b0;
            done <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            run  <= next_run;
            done <= next_done;
        end
    end
endmodule
`default_nettype wire

// ==== logic/pppc_pkg.sv ====
// Constants for the peak power and protection configuration register.
// Assumes the byte-wide register port of the device's serial interface.
package pppc_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0]  ADDR_LOW        = 8'h32;
    localparam logic [7:0]  ADDR_HIGH       = 8'h33;
    localparam logic [15:0] RESET_VALUE     = 16'h02B7;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BIT_OVLD_HI   = 15;
    localparam int BIT_OVLD_LO   = 14;
    localparam int BIT_IN_TRIG   = 13;
    localparam int BIT_SYS_TRIG  = 12;
    localparam int BIT_OVLD_FLAG = 11;
    localparam int BIT_RLX_FLAG  = 10;
    localparam int BIT_CYC_HI    = 9;
    localparam int BIT_CYC_LO    = 8;
    localparam int BIT_EXT_LIM   = 7;
    localparam int BIT_MON_DIR   = 6;
    localparam int BIT_LS_OCP    = 5;
    localparam int BIT_IN_OCP    = 4;
    localparam int BIT_INPUT_OVERCURRENT_PROTECT_EN   = 3;
    localparam int BIT_INPUT_OVERCURRENT_PROTECT_LVL  = 2;
    localparam int BIT_BATT_DISCHARGE_OVERCURRENT_EN  = 1;
    localparam int BIT_BATT_DISCHARGE_OVERCURRENT_LVL = 0;
    // ----------------------------------------
    // Timing, 20 MHz clock
    // ----------------------------------------
    localparam int CLK_HZ          = 20_000_000;
    localparam int BLANK_US        = 100;
    localparam int BLANK_CYCLES    = BLANK_US * (CLK_HZ / 1_000_000);
    localparam int MS_CYCLES       = CLK_HZ / 1000;
    localparam int OVLD_MS_0       = 1;
    localparam int OVLD_MS_1       = 2;
    localparam int OVLD_MS_2       = 10;
    localparam int OVLD_MS_3       = 20;
    localparam int CYC_MS_0        = 5;
    localparam int CYC_MS_1        = 10;
    localparam int CYC_MS_2        = 20;
    localparam int CYC_MS_3        = 40;
    localparam int CNT_W           = 24;
    // ----------------------------------------
    // Peak power sequencer states
    // ----------------------------------------
    typedef enum logic [2:0] {
        PPPC_IDLE     = 3'b001,
        PPPC_OVERLOAD = 3'b010,
        PPPC_RELAX    = 3'b100
    } pppc_state_t;
endpackage

// ==== logic/pppc_top.sv ====
// Peak power and protection configuration register with its sequencer.
// Assumes a byte-wide register port decoded by the serial interface,
// and analog comparator results already synchronous to mclk.
//
// Notes on behaviour
// - Overload time field picks 1, 2, 10 or 20 ms; default 1 ms.
// - Input overshoot trigger enable lets input overshoot start peak power.
// - System undershoot trigger enable lets undershoot start peak power.
// - Both trigger enables clear means peak power is fully off.
// - Adapter removal clears both trigger enables.
// - Overload flag set during overload; host writing 0 ends it.
// - Relax flag set during relax; host writing 0 ends it.
// - Cycle time field picks 5, 10, 20 or 40 ms; default 20 ms.
// - Overload time longer than cycle time skips relax entirely.
// - External limit enable lets pin limit join; lowest limit wins.
// - Direction bit: monitor shows discharge at 0, charge at 1.
// - Low-side switch threshold select: 210 mV at 0, 150 mV at 1.
// - Input over-current threshold select: 280 mV at 0, 150 mV at 1.
// - Input over-current enabled and detected stops converter after 100 us.
// - Input over-current level: 133 % at 0, 200 % at 1 of second limit.
// - Discharge over-current enabled and detected stops converter.
// - Discharge over-current level: 133 % at 0, 200 % at 1.
// - Upper byte at 0x33, lower at 0x32; resets to 0x02B7.
`timescale 1ns/100ps
`default_nettype none
module pppc_top #(
    parameter int LIMIT_W = 8
) (
    input  wire logic               mclk,                  // 20 MHz clock
    input  wire logic               rst_n,                 // Sync reset
    input  wire logic [7:0]         reg_addr,              // Byte address
    input  wire logic               reg_wr,                // Write strobe
    input  wire logic [7:0]         reg_wdata,             // Write byte
    output logic      [7:0]         reg_rdata,             // Read byte
    input  wire logic               adapter_present,       // Adapter attached
    input  wire logic               input_overshoot,       // Input current overshoot
    input  wire logic               sys_undershoot,        // System voltage dip
    input  wire logic               input_oc_detect,       // Input over-current
    input  wire logic               batt_oc_detect,        // Discharge over-current
    input  wire logic [LIMIT_W-1:0] limit_pin,             // External limit code
    input  wire logic [LIMIT_W-1:0] dynamic_input_limit,   // Dynamic limit
    input  wire logic [LIMIT_W-1:0] host_input_limit,      // Host limit
    output logic      [LIMIT_W-1:0] input_limit,           // Limit in effect
    output logic                    peak_power_enabled,    // Peak power armed
    output logic                    peak_overload,         // In overload cycle
    output logic                    peak_relax,            // In relax cycle
    output logic                    monitor_charge_dir,    // 1 reports charge
    output logic                    low_side_ocp_150mv,    // 150 mV threshold
    output logic                    input_ocp_150mv,       // 150 mV threshold
    output logic                    input_oc_level_200,    // 200 % of second limit
    output logic                    batt_oc_level_200,     // 200 % of discharge level
    output logic                    converter_off          // Protection latch
);
    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [15:0]           cfg;
    logic [15:0]           next_cfg;
    pppc_pkg::pppc_state_t state;
    pppc_pkg::pppc_state_t next_state;
    logic                  next_off;
    logic [LIMIT_W-1:0]    next_limit;
    logic                  wr_hi;
    logic                  wr_lo;
    logic                  input_overcurrent_protect_fired;
    logic                  t_start;
    logic                  t_stop;
    logic                  t_done;
    logic [5:0]            t_ms;
    logic [5:0]            ovld_ms;
    logic [5:0]            cyc_ms;
    logic                  trigger;

    assign wr_hi = reg_wr && (reg_addr == pppc_pkg::ADDR_HIGH);
    assign wr_lo = reg_wr && (reg_addr == pppc_pkg::ADDR_LOW);

    // ----------------------------------------
    // Field decode
    // ----------------------------------------
    always_comb begin
        case (cfg[pppc_pkg::BIT_OVLD_HI:pppc_pkg::BIT_OVLD_LO])
            2'h0:    ovld_ms = 6'(pppc_pkg::OVLD_MS_0);
            2'h1:    ovld_ms = 6'(pppc_pkg::OVLD_MS_1);
            2'h2:    ovld_ms = 6'(pppc_pkg::OVLD_MS_2);
            default: ovld_ms = 6'(pppc_pkg::OVLD_MS_3);
        endcase
        case (cfg[pppc_pkg::BIT_CYC_HI:pppc_pkg::BIT_CYC_LO])
            2'h0:    cyc_ms = 6'(pppc_pkg::CYC_MS_0);
            2'h1:    cyc_ms = 6'(pppc_pkg::CYC_MS_1);
            2'h2:    cyc_ms = 6'(pppc_pkg::CYC_MS_2);
            default: cyc_ms = 6'(pppc_pkg::CYC_MS_3);
        endcase
    end

    assign peak_power_enabled = cfg[pppc_pkg::BIT_IN_TRIG]
                              | cfg[pppc_pkg::BIT_SYS_TRIG];
    assign trigger = (cfg[pppc_pkg::BIT_IN_TRIG] && input_overshoot)
                   | (cfg[pppc_pkg::BIT_SYS_TRIG] && sys_undershoot);

    // ----------------------------------------
    // Peak power sequencer
    // ----------------------------------------
    // Overload lasts the overload time; relax lasts the cycle time.
    always_comb begin
        next_state = state;
        t_start    = 1'b0;
        t_stop     = 1'b0;
        t_ms       = ovld_ms;
        case (state)
            pppc_pkg::PPPC_IDLE: begin
                if (trigger) begin
                    next_state = pppc_pkg::PPPC_OVERLOAD;
                    t_start    = 1'b1;
                end
            end
            pppc_pkg::PPPC_OVERLOAD: begin
                if (!peak_power_enabled
                    || (wr_hi && !reg_wdata[pppc_pkg::BIT_OVLD_FLAG - 8])) begin
                    next_state = pppc_pkg::PPPC_IDLE;
                    t_stop     = 1'b1;
                end else if (t_done) begin
                    if (ovld_ms > cyc_ms) begin
                        next_state = pppc_pkg::PPPC_IDLE;
                    end else begin
                        next_state = pppc_pkg::PPPC_RELAX;
                        t_start    = 1'b1;
                        t_ms       = cyc_ms;
                    end
                end
            end
            pppc_pkg::PPPC_RELAX: begin
                if (!peak_power_enabled || t_done
                    || (wr_hi && !reg_wdata[pppc_pkg::BIT_RLX_FLAG - 8])) begin
                    next_state = pppc_pkg::PPPC_IDLE;
                    t_stop     = 1'b1;
                end
            end
            default: next_state = pppc_pkg::PPPC_IDLE;
        endcase
    end

    pppc_ms_timer #(
        .MS_CYCLES (pppc_pkg::MS_CYCLES)
    ) u_timer (
        .mclk  (mclk),
        .rst_n (rst_n),
        .start (t_start),
        .stop  (t_stop),
        .ms    (t_ms),
        .done  (t_done)
    );

    pppc_blanking #(
        .CYCLES (pppc_pkg::BLANK_CYCLES)
    ) u_blank (
        .mclk  (mclk),
        .rst_n (rst_n),
        .level (cfg[pppc_pkg::BIT_INPUT_OVERCURRENT_PROTECT_EN] && input_oc_detect),
        .fired (input_overcurrent_protect_fired)
    );

    // ----------------------------------------
    // Register update
    // ----------------------------------------
    always_comb begin
        next_cfg = cfg;
        if (wr_hi) begin
            next_cfg[15:8] = reg_wdata;
        end
        if (wr_lo) begin
            next_cfg[7:0] = reg_wdata;
        end
        // Flags mirror the sequencer; a host 1 cannot start a cycle
        next_cfg[pppc_pkg::BIT_OVLD_FLAG] = (next_state == pppc_pkg::PPPC_OVERLOAD);
        next_cfg[pppc_pkg::BIT_RLX_FLAG]  = (next_state == pppc_pkg::PPPC_RELAX);
        if (!adapter_present) begin
            next_cfg[pppc_pkg::BIT_IN_TRIG]  = 1'b0;
            next_cfg[pppc_pkg::BIT_SYS_TRIG] = 1'b0;
        end
    end

    // ----------------------------------------
    // Protection and limit
    // ----------------------------------------
    // Latched until reset; restart policy belongs to the power stage.
    always_comb begin
        next_off = converter_off | input_overcurrent_protect_fired
                 | (cfg[pppc_pkg::BIT_BATT_DISCHARGE_OVERCURRENT_EN] && batt_oc_detect);
        next_limit = (dynamic_input_limit < host_input_limit)
                   ? dynamic_input_limit : host_input_limit;
        if (cfg[pppc_pkg::BIT_EXT_LIM] && (limit_pin < next_limit)) begin
            next_limit = limit_pin;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cfg           <= pppc_pkg::RESET_VALUE;
            state         <= pppc_pkg::PPPC_IDLE;
            converter_off <= 1'b0;
            input_limit   <= '0;
        end else begin
            cfg           <= next_cfg;
            state         <= next_state;
            converter_off <= next_off;
            input_limit   <= next_limit;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign reg_rdata = (reg_addr == pppc_pkg::ADDR_HIGH) ? cfg[15:8]
                     : (reg_addr == pppc_pkg::ADDR_LOW)  ? cfg[7:0] : 8'h00;
    assign peak_overload      = cfg[pppc_pkg::BIT_OVLD_FLAG];
    assign peak_relax         = cfg[pppc_pkg::BIT_RLX_FLAG];
    assign monitor_charge_dir = cfg[pppc_pkg::BIT_MON_DIR];
    assign low_side_ocp_150mv = cfg[pppc_pkg::BIT_LS_OCP];
    assign input_ocp_150mv    = cfg[pppc_pkg::BIT_IN_OCP];
    assign input_oc_level_200 = cfg[pppc_pkg::BIT_INPUT_OVERCURRENT_PROTECT_LVL];
    assign batt_oc_level_200  = cfg[pppc_pkg::BIT_BATT_DISCHARGE_OVERCURRENT_LVL];
endmodule
`default_nettype wire

// ==== verification/pppc_host_model.sv ====
// Host model: byte writes and reads on the register port.
// Assumes a free running mclk; the bench calls its tasks.
`timescale 1ns/100ps
`default_nettype none
module pppc_host_model (
    output logic      [7:0] reg_addr,  // Byte address
    output logic            reg_wr,    // Write strobe
    output logic      [7:0] reg_wdata, // Write byte
    input  wire logic [7:0] reg_rdata, // Read byte
    input  wire logic       mclk       // Clock
);
    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    initial begin
        reg_addr  = 8'hFF;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge mclk);
        reg_wr    = 1'b0;
        // Stale data inverted so a late sample cannot pass
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        #5;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ==== verification/pppc_top_asserts.sv ====
// Port-level checker for the peak power configuration register block.
// Assumes it is bound into every pppc_top instance.
`timescale 1ns/100ps
`default_nettype none
module pppc_top_asserts #(
    parameter int LIMIT_W = 8
) (
    input wire logic               mclk,                // Clock
    input wire logic               rst_n,               // Sync reset
    input wire logic [7:0]         reg_addr,            // Byte address
    input wire logic               reg_wr,              // Write strobe
    input wire logic [7:0]         reg_wdata,           // Write byte
    input wire logic [7:0]         reg_rdata,           // Read byte
    input wire logic               adapter_present,     // Adapter attached
    input wire logic               batt_oc_detect,      // Discharge fault
    input wire logic [LIMIT_W-1:0] limit_pin,           // External limit
    input wire logic [LIMIT_W-1:0] dynamic_input_limit, // Dynamic limit
    input wire logic [LIMIT_W-1:0] host_input_limit,    // Host limit
    input wire logic [LIMIT_W-1:0] input_limit,         // Limit in effect
    input wire logic               peak_power_enabled,  // Armed
    input wire logic               peak_overload,       // Overload cycle
    input wire logic               peak_relax,          // Relax cycle
    input wire logic               monitor_charge_dir,  // Monitor direction
    input wire logic               low_side_ocp_150mv,  // Switch threshold
    input wire logic               input_ocp_150mv,     // Input threshold
    input wire logic               input_oc_level_200,  // Input level
    input wire logic               batt_oc_level_200,   // Discharge level
    input wire logic               converter_off        // Protection latch
);
    // ----------------------------------------
    // Helpers and properties
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic               idle;
    logic               lo_sel;
    logic [7:0]         wd_q;
    logic [LIMIT_W-1:0] lim_a;
    logic [LIMIT_W-1:0] lim_exp;
    assign idle    = !peak_overload && !peak_relax;
    assign lo_sel  = reg_addr == pppc_pkg::ADDR_LOW;
    assign lim_a   = (dynamic_input_limit < host_input_limit) ? dynamic_input_limit
                                                              : host_input_limit;
    // Bit 7 is only visible while the low byte is addressed
    assign lim_exp = (reg_rdata[7] && limit_pin < lim_a) ? limit_pin : lim_a;
    always_ff @(posedge mclk) begin
        wd_q <= reg_wdata;
    end
    no_trigger_a: assert property (!peak_power_enabled && idle |=> !peak_overload)
        else $error("overload started while disarmed");
    adapter_clear_a: assert property (!adapter_present |=> !peak_power_enabled)
        else $error("trigger enables survive adapter removal");
    unmapped_zero_a: assert property (
        !lo_sel && reg_addr != pppc_pkg::ADDR_HIGH |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    low_write_a: assert property (
        reg_wr && lo_sel |=> {monitor_charge_dir, low_side_ocp_150mv, input_ocp_150mv,
        input_oc_level_200, batt_oc_level_200}
        == {wd_q[6], wd_q[5], wd_q[4], wd_q[2], wd_q[0]})
        else $error("low byte outputs do not follow write");
    // Relax is only ever reached straight out of an overload cycle
    relax_order_a: assert property ($rose(peak_relax) |-> $past(peak_overload))
        else $error("relax entered without overload");
    ovld_exit_a: assert property (peak_overload && reg_wr && !reg_wdata[3]
        && reg_addr == pppc_pkg::ADDR_HIGH |=> !peak_overload)
        else $error("overload kept after clear");
    relax_exit_a: assert property (peak_relax && reg_wr && !reg_wdata[2]
        && reg_addr == pppc_pkg::ADDR_HIGH |=> !peak_relax)
        else $error("relax kept after clear");
    batt_trip_a: assert property (batt_oc_detect && lo_sel && reg_rdata[1] && !reg_wr
        |=> converter_off)
        else $error("discharge fault did not stop converter");
    off_sticky_a: assert property (converter_off |=> converter_off)
        else $error("converter released without reset");
    limit_min_a: assert property (lo_sel && !reg_wr |=> input_limit == $past(lim_exp))
        else $error("input limit not the lowest");
    cover property (idle ##1 peak_overload);
    cover property (peak_overload ##1 peak_relax);
    cover property ($rose(converter_off));
endmodule
bind pppc_top pppc_top_asserts #(.LIMIT_W(LIMIT_W)) chk_i (.mclk, .rst_n, .reg_addr,
    .reg_wr, .reg_wdata, .reg_rdata, .adapter_present, .batt_oc_detect, .limit_pin,
    .dynamic_input_limit, .host_input_limit, .input_limit, .peak_power_enabled,
    .peak_overload, .peak_relax, .monitor_charge_dir, .low_side_ocp_150mv,
    .input_ocp_150mv, .input_oc_level_200, .batt_oc_level_200, .converter_off);
`default_nettype wire

// ==== verification/pppc_top_test.sv ====
// Self-checking bench for pppc_top driven through the host model.
// Assumes the package and design files are compiled first.
`timescale 1ns/100ps
`default_nettype none
module pppc_top_test;
    // ----------------------------------------
    // Signals, tasks and sequence
    // ----------------------------------------
    logic       mclk = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, limit_pin, dynamic_input_limit, rb;
    logic [7:0] host_input_limit, input_limit;
    logic       reg_wr, adapter_present, input_overshoot, sys_undershoot, input_oc_detect;
    logic       batt_oc_detect, peak_power_enabled, peak_overload, peak_relax;
    logic       monitor_charge_dir, low_side_ocp_150mv, input_ocp_150mv;
    logic       input_oc_level_200, batt_oc_level_200, converter_off;
    int         err_count = 0;
    int         num_checks = 0;
    int         seed = 24;
    int         cyc = 0;
    int         n;
    logic [7:0] lo_seen;
    logic [7:0] exp_b;
    assign lo_seen = {3'h0, monitor_charge_dir, low_side_ocp_150mv, input_ocp_150mv,
                      input_oc_level_200, batt_oc_level_200};
    always #25 mclk = ~mclk;
    pppc_top #(.LIMIT_W(8)) DUT (.mclk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
        .adapter_present, .input_overshoot, .sys_undershoot, .input_oc_detect,
        .batt_oc_detect, .limit_pin, .dynamic_input_limit, .host_input_limit, .input_limit,
        .peak_power_enabled, .peak_overload, .peak_relax, .monitor_charge_dir,
        .low_side_ocp_150mv, .input_ocp_150mv, .input_oc_level_200, .batt_oc_level_200,
        .converter_off);
    pppc_host_model host (.reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .mclk);
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkb(input string nm, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic tally_and_finish();
        if (err_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    function automatic logic [7:0] lim(input logic en, input logic [7:0] p, d, h);
        logic [7:0] m;
        m = (d < h) ? d : h;
        return (en && p < m) ? p : m;
    endfunction
    function automatic logic [7:0] low_exp(input logic [7:0] w);
        return {3'h0, w[6], w[5], w[4], w[2], w[0]};
    endfunction
    task automatic hold(input int c);
        repeat (c) @(negedge mclk);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        hold(1);
        s = 1'b0;
    endtask
    task automatic reset_dut();
        rst_n = 1'b0;
        hold(2);
        rst_n = 1'b1;
    endtask
    // Whole run needs about 23k cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            tally_and_finish();
        end
    end
    initial begin
        {adapter_present, input_overshoot, sys_undershoot, input_oc_detect} = 4'h0;
        batt_oc_detect = 1'b0;
        {limit_pin, dynamic_input_limit, host_input_limit} = 24'hFFFFFF;
        hold(2);
        rst_n = 1'b1;
        host.rd(8'h33, rb);
        chk("high reset", 8'h02, rb);
        host.rd(8'h32, rb);
        chk("low reset", 8'hB7, rb);
        host.rd(8'h34, rb);
        chk("unmapped", 8'h00, rb);
        host.wr(8'h33, 8'hFF);
        host.rd(8'h33, rb);
        chk("ones refused", 8'hC3, rb);
        adapter_present = 1'b1;
        host.wr(8'h33, 8'h20);
        chkb("armed", 1'b1, peak_power_enabled);
        pulse(input_overshoot);
        chkb("overshoot start", 1'b1, peak_overload);
        host.rd(8'h33, rb);
        chk("overload flag", 8'h28, rb);
        host.wr(8'h33, 8'h20);
        hold(1);
        chkb("overload left", 1'b0, peak_overload);
        host.wr(8'h33, 8'h10);
        pulse(input_overshoot);
        chkb("overshoot off", 1'b0, peak_overload);
        pulse(sys_undershoot);
        chkb("undershoot start", 1'b1, peak_overload);
        n = 0;
        while (!peak_relax && n < 21000) begin
            hold(1);
            n++;
        end
        chkb("overload span", 1'b1, n > 19995 && n < 20005);
        host.rd(8'h33, rb);
        chk("relax flag", 8'h14, rb);
        host.wr(8'h33, 8'h10);
        hold(1);
        chkb("relax left", 1'b0, peak_relax);
        host.wr(8'h33, 8'h00);
        chkb("disarmed", 1'b0, peak_power_enabled);
        {input_overshoot, sys_undershoot} = 2'b11;
        hold(3);
        chkb("both disabled", 1'b0, peak_overload);
        {input_overshoot, sys_undershoot} = 2'b00;
        host.wr(8'h33, 8'h30);
        adapter_present = 1'b0;
        hold(2);
        host.rd(8'h33, rb);
        chk("adapter gone", 8'h00, rb);
        for (int i = 0; i < 40; i++) begin
            rb = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
            {limit_pin, dynamic_input_limit, host_input_limit} = 24'($random(seed));
            if (i == 2)
                dynamic_input_limit = limit_pin;
            host.wr(8'h32, rb);
            hold(1);
            exp_b = lim(rb[7], limit_pin, dynamic_input_limit, host_input_limit);
            chk("low outputs", low_exp(rb), lo_seen);
            chk("limit", exp_b, input_limit);
        end
        reset_dut();
        host.wr(8'h32, 8'h08);
        input_oc_detect = 1'b1;
        hold(1000);
        input_oc_detect = 1'b0;
        batt_oc_detect = 1'b1;
        hold(2);
        chkb("short fault", 1'b0, converter_off);
        batt_oc_detect = 1'b0;
        input_oc_detect = 1'b1;
        hold(1990);
        chkb("blanking", 1'b0, converter_off);
        hold(15);
        chkb("input trip", 1'b1, converter_off);
        input_oc_detect = 1'b0;
        reset_dut();
        pulse(batt_oc_detect);
        chkb("discharge trip", 1'b1, converter_off);
        tally_and_finish();
    end
endmodule
`default_nettype wire
